// ---- rtl/pscr_params.svh ----
// Offsets, field positions, reset values and sizes for the clock multiplier and sync registers.
// Assumes inclusion by bare name from the package and the register module.
`ifndef PSCR_PARAMS_SVH
`define PSCR_PARAMS_SVH

// ============================================================
// Register offsets
`define PSCR_OFF_DIVIDER   8'h0d
`define PSCR_OFF_LOCK      8'h0e
`define PSCR_OFF_BAND      8'h0f
`define PSCR_OFF_SYNCCTL   8'h10
`define PSCR_OFF_PHASEREQ  8'h11
`define PSCR_OFF_PHASERB   8'h13

// ============================================================
// Field positions
`define PSCR_LOCK_BIT      7
`define PSCR_SYNC_EN_BIT   7
`define PSCR_SYNC_RATE_BIT 6
`define PSCR_SYNC_EDGE_BIT 3
`define PSCR_OSC_DIV_HI    3
`define PSCR_OSC_DIV_LO    2

// ============================================================
// Reset values
`define PSCR_RST_OSC_DIV   2'h2
`define PSCR_RST_LOOP_DIV  2'h1
`define PSCR_RST_SYNC_EN   1'h0
`define PSCR_RST_RATE      1'h1
`define PSCR_RST_EDGE      1'h1
`define PSCR_RST_AVG       3'h0
`define PSCR_RST_PHASEREQ  6'h00

// ============================================================
// Sizes
`define PSCR_FRAC_BITS     2
`define PSCR_SUM_W         15
`define PSCR_CNT_W         8

`endif

// ---- rtl/pscr_pkg.sv ----
// Types shared by the clock multiplier and sync register block.
// Assumes the constants header sits on the include path.
`include "pscr_params.svh"

package pscr_pkg;

    // ============================================================
    // Register contents
    typedef struct packed {
        logic [1:0] oscDiv;
        logic [1:0] loopDiv;
    } pscr_divider_s;

    typedef struct packed {
        logic       enable;
        logic       rateData;
        logic       risingEdge;
        logic [2:0] avgCode;
    } pscr_syncctl_s;

    // Analog status sampled from the clock multiplier.
    typedef struct packed {
        logic       locked;
        logic [3:0] ctrlVoltage;
        logic [5:0] band;
    } pscr_pllstat_s;

    typedef enum logic [0:0] {
        PSCR_IDLE  = 1'b0,
        PSCR_ACCUM = 1'b1
    } pscr_state_e;

endpackage

// ---- rtl/pscr_regs.sv ----
// Clock multiplier divider, lock readback and multi-chip sync registers with sync logic.
// Assumes a serial port front end that presents decoded byte reads and writes on sys_clk,
// and a sync input already synchronous to sys_clk, which stands for the sample clock.
//
// Notes on behaviour
// - Oscillator divider codes 10 and 11 both give an oscillator four times the sample clock.
// - The loop divider code 00, 01, 10, 11 gives sample to reference ratio 2, 4, 8, 16, reset 01.
// - Bit 7 of the lock status register reads 1 while the multiplier tracks the reference.
// - Bits 3 to 0 of the lock status register return the oscillator control voltage.
// - A separate register returns the selected 6-bit oscillator band.
// - Sync control bit 7 enables the sync logic and resets to 0.
// - Sync control bit 6 picks FIFO reset rate when 0 and data rate when 1, reset 1.
// - Sync control bit 3 picks the rising sync edge when 1 and the falling edge when 0, reset 1.
// - The 3-bit averaging code averages two to the code samples of sync phase, reset 000.
// - The 6-bit phase request gives an offset of 0 to 63 sample cycles, reset 0.
// - The phase request shifts the output frame relative to the sync input.
// - The averaged phase reads back in 6.2 format and, while sync is locked, a mismatch with the request flags an error.
`timescale 1ns/1ps
`include "pscr_params.svh"

module pscr_regs
    import pscr_pkg::*;
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Register port
    input  wire logic [7:0]    regAddr,
    input  wire logic          regWrEn,
    input  wire logic [7:0]    regWrData,
    output logic      [7:0]    regRdData,
    // Clock multiplier
    input  pscr_pllstat_s      pllStatus,
    output logic      [4:0]    loopRatio,
    output logic      [2:0]    oscRatio,
    // Sync
    input  wire logic          syncIn,
    input  wire logic          fifoResetReq,
    output logic               syncLocked,
    output logic               syncTimingError,
    output logic               frameStrobe
);

    // ============================================================
    // Decoding functions
    function automatic logic [4:0] loop_ratio(input logic [1:0] code);
        loop_ratio = 5'h02 << code;
    endfunction

    function automatic logic [2:0] osc_ratio(input logic [1:0] code);
        osc_ratio = code[1] ? 3'h4 : (3'h1 << code[0]);
    endfunction

    // ============================================================
    // Configuration registers
    pscr_divider_s divider_q,   divider_d;
    pscr_syncctl_s syncCtl_q,   syncCtl_d;
    logic [5:0]    phaseReq_q,  phaseReq_d;
    logic [4:0]    loopRatio_q, loopRatio_d;
    logic [2:0]    oscRatio_q,  oscRatio_d;

    always_comb
    begin
        divider_d   = divider_q;
        syncCtl_d   = syncCtl_q;
        phaseReq_d  = phaseReq_q;
        if (regWrEn)
        begin
            unique case (regAddr)
                `PSCR_OFF_DIVIDER:
                begin
                    divider_d.oscDiv  = regWrData[`PSCR_OSC_DIV_HI:`PSCR_OSC_DIV_LO];
                    divider_d.loopDiv = regWrData[1:0];
                end
                `PSCR_OFF_SYNCCTL:
                begin
                    syncCtl_d.enable     = regWrData[`PSCR_SYNC_EN_BIT];
                    syncCtl_d.rateData   = regWrData[`PSCR_SYNC_RATE_BIT];
                    syncCtl_d.risingEdge = regWrData[`PSCR_SYNC_EDGE_BIT];
                    syncCtl_d.avgCode    = regWrData[2:0];
                end
                `PSCR_OFF_PHASEREQ: phaseReq_d = regWrData[5:0];
                default: ;
            endcase
        end
        loopRatio_d = loop_ratio(divider_q.loopDiv);
        oscRatio_d  = osc_ratio(divider_q.oscDiv);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            divider_q   <= '{oscDiv: `PSCR_RST_OSC_DIV, loopDiv: `PSCR_RST_LOOP_DIV};
            syncCtl_q   <= '{enable: `PSCR_RST_SYNC_EN, rateData: `PSCR_RST_RATE,
                             risingEdge: `PSCR_RST_EDGE, avgCode: `PSCR_RST_AVG};
            phaseReq_q  <= `PSCR_RST_PHASEREQ;
            loopRatio_q <= 5'h04;
            oscRatio_q  <= 3'h4;
        end
        else
        begin
            divider_q   <= divider_d;
            syncCtl_q   <= syncCtl_d;
            phaseReq_q  <= phaseReq_d;
            loopRatio_q <= loopRatio_d;
            oscRatio_q  <= oscRatio_d;
        end
    end

    assign loopRatio = loopRatio_q;
    assign oscRatio  = oscRatio_q;

    // ============================================================
    // Sync phase measurement and averaging
    // A free-running sample-cycle counter is captured on each chosen sync edge.
    // Edges only count at FIFO reset rate while a FIFO reset is requested.
    pscr_state_e           state_q,    state_d;
    logic                  syncPrev_q, syncPrev_d;
    logic [5:0]            cycleCnt_q, cycleCnt_d;
    logic [`PSCR_SUM_W-1:0] sum_q,     sum_d;
    logic [`PSCR_CNT_W-1:0] samples_q, samples_d;
    logic [7:0]            phaseRb_q,  phaseRb_d;
    logic                  locked_q,   locked_d;
    logic [5:0]            alignCnt_q, alignCnt_d;
    logic                  strobe_q,   strobe_d;
    logic                  syncEdge;
    logic                  edgeOk;
    logic [`PSCR_CNT_W-1:0] target;
    logic [`PSCR_SUM_W-1:0] sumNext;

    always_comb
    begin
        syncPrev_d = syncIn;
        cycleCnt_d = cycleCnt_q + 6'h01;
        syncEdge   = syncCtl_q.risingEdge ? (syncIn && !syncPrev_q)
                                          : (!syncIn && syncPrev_q);
        edgeOk     = syncCtl_q.enable && syncEdge
                     && (syncCtl_q.rateData || fifoResetReq);
        target     = `PSCR_CNT_W'(1) << syncCtl_q.avgCode;
        sumNext    = sum_q + `PSCR_SUM_W'({cycleCnt_q, {`PSCR_FRAC_BITS{1'b0}}});
        state_d    = state_q;
        sum_d      = sum_q;
        samples_d  = samples_q;
        phaseRb_d  = phaseRb_q;
        locked_d   = locked_q && syncCtl_q.enable;
        alignCnt_d = alignCnt_q + 6'h01;
        unique case (state_q)
            PSCR_IDLE:
            begin
                sum_d     = '0;
                samples_d = '0;
                if (edgeOk)
                begin
                    state_d   = PSCR_ACCUM;
                    sum_d     = sumNext;
                    samples_d = `PSCR_CNT_W'(1);
                end
            end
            PSCR_ACCUM:
            begin
                if (!syncCtl_q.enable)
                    state_d = PSCR_IDLE;
                else if (samples_q == target)
                begin
                    // Shifting by the code divides the sum by the sample count.
                    phaseRb_d  = 8'(sum_q >> syncCtl_q.avgCode);
                    locked_d   = 1'b1;
                    alignCnt_d = '0;
                    state_d    = PSCR_IDLE;
                end
                else if (edgeOk)
                begin
                    sum_d     = sumNext;
                    samples_d = samples_q + `PSCR_CNT_W'(1);
                end
            end
        endcase
        strobe_d = locked_q && (alignCnt_q == phaseReq_q);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= PSCR_IDLE;
            syncPrev_q <= 1'b0;
            cycleCnt_q <= '0;
            sum_q      <= '0;
            samples_q  <= '0;
            phaseRb_q  <= '0;
            locked_q   <= 1'b0;
            alignCnt_q <= '0;
            strobe_q   <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            syncPrev_q <= syncPrev_d;
            cycleCnt_q <= cycleCnt_d;
            sum_q      <= sum_d;
            samples_q  <= samples_d;
            phaseRb_q  <= phaseRb_d;
            locked_q   <= locked_d;
            alignCnt_q <= alignCnt_d;
            strobe_q   <= strobe_d;
        end
    end

    assign syncLocked  = locked_q;
    assign frameStrobe = strobe_q;

    // ============================================================
    // Read path and status
    logic [7:0] rdData_q, rdData_d;
    logic       err_q,    err_d;

    always_comb
    begin
        rdData_d = 8'h00;
        unique case (regAddr)
            `PSCR_OFF_DIVIDER:  rdData_d = {4'h0, divider_q.oscDiv, divider_q.loopDiv};
            `PSCR_OFF_LOCK:     rdData_d = {pllStatus.locked, 3'h0,
                                            pllStatus.ctrlVoltage};
            `PSCR_OFF_BAND:     rdData_d = {2'h0, pllStatus.band};
            `PSCR_OFF_SYNCCTL:  rdData_d = {syncCtl_q.enable, syncCtl_q.rateData, 2'h0,
                                            syncCtl_q.risingEdge, syncCtl_q.avgCode};
            `PSCR_OFF_PHASEREQ: rdData_d = {2'h0, phaseReq_q};
            `PSCR_OFF_PHASERB:  rdData_d = phaseRb_q;
            default:            rdData_d = 8'h00;
        endcase
        err_d = locked_q && (phaseRb_q != {phaseReq_q, 2'h0});
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdData_q <= 8'h00;
            err_q    <= 1'b0;
        end
        else
        begin
            rdData_q <= rdData_d;
            err_q    <= err_d;
        end
    end

    assign regRdData       = rdData_q;
    assign syncTimingError = err_q;

endmodule // pscr_regs

// ---- sim/pscr_regs_sva.sv ----
// Port assertions for the clock multiplier and sync registers.
// Assumes one clock, sys_clk, and binding to every pscr_regs.
`timescale 1ns/1ps
module pscr_regs_sva
    import pscr_pkg::*;
(
    // Clock and reset
    input wire logic          sys_clk,
    input wire logic          rst_n,
    // Register port
    input wire logic [7:0]    regAddr,
    input wire logic          regWrEn,
    input wire logic [7:0]    regWrData,
    input wire logic [7:0]    regRdData,
    // Clock multiplier and sync
    input wire pscr_pllstat_s pllStatus,
    input wire logic [4:0]    loopRatio,
    input wire logic [2:0]    oscRatio,
    input wire logic          syncLocked,
    input wire logic          syncTimingError,
    input wire logic          frameStrobe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [1:0] loopCodeQ;
    // ========
    // Last loop code written, for the ratio check.
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            loopCodeQ <= 2'h1;
        else if (regWrEn && regAddr == 8'h0d)
            loopCodeQ <= regWrData[1:0];
    a_osc_ratio_four: assert property (
        regWrEn && regAddr == 8'h0d && regWrData[3] ##1 !(regWrEn && regAddr == 8'h0d)
        |=> oscRatio == 3'h4) else $error("oscillator ratio not four");
    a_loop_ratio_map: assert property (
        regWrEn && regAddr == 8'h0d ##1 !(regWrEn && regAddr == 8'h0d)
        |=> loopRatio == (5'h2 << loopCodeQ)) else $error("loop ratio wrong");
    a_lock_readback: assert property (
        (regAddr == 8'h0e && $stable(pllStatus)) [*3] ##1 $stable(pllStatus)
        |-> regRdData == {pllStatus.locked, 3'h0, pllStatus.ctrlVoltage})
        else $error("lock status readback wrong");
    a_band_readback: assert property (
        (regAddr == 8'h0f && $stable(pllStatus)) [*3] ##1 $stable(pllStatus)
        |-> regRdData == {2'h0, pllStatus.band}) else $error("band readback wrong");
    a_enable_drop: assert property (
        regWrEn && regAddr == 8'h10 && !regWrData[7] |-> ##2 !syncLocked)
        else $error("sync lock kept while disabled");
    a_strobe_pulse: assert property (
        frameStrobe |=> !frameStrobe [*8]) else $error("frame strobe too long");
    a_error_needs_lock: assert property (
        !syncLocked [*2] |-> !syncTimingError) else $error("timing error without lock");
    a_unmapped_zero: assert property (
        regAddr == 8'h20 |=> regRdData == 8'h00) else $error("unmapped read not zero");
    c_lock: cover property ($rose(syncLocked));
    c_strobe: cover property (frameStrobe);
    c_error: cover property (syncTimingError);
endmodule // pscr_regs_sva

bind pscr_regs pscr_regs_sva i_pscr_regs_sva (.sys_clk, .rst_n, .regAddr, .regWrEn,
    .regWrData, .regRdData, .pllStatus, .loopRatio, .oscRatio, .syncLocked,
    .syncTimingError, .frameStrobe);

// ---- sim/pscr_sync_src.sv ----
// Far side model: sync source, FIFO reset request and multiplier status.
// Assumes its tasks are called from the bench; all changes follow a rising edge.
`timescale 1ns/1ps
module pscr_sync_src
    import pscr_pkg::*;
(
    // Clock
    input wire logic      sys_clk,
    // Far side outputs
    output logic          syncIn,
    output logic          fifoResetReq,
    output pscr_pllstat_s pllStatus
);
    initial
    begin
        syncIn = 1'b0;
        fifoResetReq = 1'b0;
        pllStatus = '0;
    end
    // Moves the sync line, then holds it for the given cycles.
    task automatic level(input logic v, input int hold);
        @(posedge sys_clk) syncIn <= v;
        repeat (hold) @(posedge sys_clk);
    endtask
    task automatic fifo(input logic v);
        @(posedge sys_clk) fifoResetReq <= v;
    endtask
    task automatic status(input pscr_pllstat_s s);
        @(posedge sys_clk) pllStatus <= s;
    endtask
endmodule // pscr_sync_src

// ---- sim/test_pscr_regs.sv ----
// Self-checking bench for the clock multiplier and sync registers.
// Assumes the package, pscr_regs, the far side model and the checker.
`timescale 1ns/1ps
module test_pscr_regs;
    import pscr_pkg::*;
    logic          sys_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic [7:0]    regAddr = 8'h00;
    logic          regWrEn = 1'b0;
    logic [7:0]    regWrData = 8'h00;
    logic [7:0]    regRdData;
    pscr_pllstat_s pllStatus;
    logic [4:0]    loopRatio;
    logic [2:0]    oscRatio;
    logic          syncIn, fifoResetReq, syncLocked, syncTimingError, frameStrobe;
    int            miscompares = 0;
    int            checks_done = 0;
    always #2.5 sys_clk = ~sys_clk;
    pscr_regs i_pscr_regs (.sys_clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdData,
        .pllStatus, .loopRatio, .oscRatio, .syncIn, .fifoResetReq, .syncLocked,
        .syncTimingError, .frameStrobe);
    pscr_sync_src i_pscr_sync_src (.sys_clk, .syncIn, .fifoResetReq, .pllStatus);
    // ========
    // Compares and register cycles
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkCnt(input int got, input int exp);
        checks_done++;
        if (got != exp)
        begin
            miscompares++;
            $display("ERROR %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk)
        begin
            regAddr <= a;
            regWrEn <= 1'b1;
            regWrData <= d;
        end
        @(posedge sys_clk) regWrEn <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk) regAddr <= a;
        @(posedge sys_clk);
        #1 chk(regRdData, exp);
    endtask
    // Counts edges until lock (strobe = 0) or frame strobe (strobe = 1).
    task automatic waitFor(input bit strobe, input int n, output int c);
        c = 0;
        do
        begin
            @(posedge sys_clk);
            #1 c++;
        end while (c < n && (strobe ? frameStrobe : syncLocked) !== 1'b1);
    endtask
    // ========
    // Scenarios
    task automatic t_registers();
        logic [2:0] osc [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
        rdChk(8'h0d, 8'h09);
        rdChk(8'h10, 8'h48);
        rdChk(8'h11, 8'h00);
        rdChk(8'h20, 8'h00);
        wr(8'h13, 8'hff);
        rdChk(8'h13, 8'h00);
        wr(8'h10, 8'hff);
        rdChk(8'h10, 8'hcf);
        wr(8'h11, 8'hff);
        rdChk(8'h11, 8'h3f);
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h0d, 8'(c * 5));
            repeat (2) @(posedge sys_clk);
            #1 chk({3'h0, loopRatio}, 8'(2 << c));
            chk({5'h0, oscRatio}, {5'h0, osc[c]});
        end
        wr(8'h0d, 8'hff);
        rdChk(8'h0d, 8'h0f);
        i_pscr_sync_src.status('{1'b1, 4'ha, 6'h2d});
        wr(8'h0e, 8'h00);
        wr(8'h0f, 8'h00);
        rdChk(8'h0e, 8'h8a);
        rdChk(8'h0f, 8'h2d);
        i_pscr_sync_src.status('{1'b0, 4'h5, 6'h12});
        rdChk(8'h0e, 8'h05);
        rdChk(8'h0f, 8'h12);
    endtask
    task automatic phaseRun(input logic [5:0] req, output int c);
        int p;
        logic [7:0] rb;
        wr(8'h10, 8'h48);
        wr(8'h11, {2'h0, req});
        wr(8'h10, 8'hc8);
        i_pscr_sync_src.level(1'b1, 0);
        waitFor(1'b0, 8, p);
        waitFor(1'b1, 80, c);
        waitFor(1'b1, 80, p);
        chkCnt(p, 64);
        @(posedge sys_clk) regAddr <= 8'h13;
        @(posedge sys_clk);
        #1 rb = regRdData;
        chk({7'h0, syncTimingError}, {7'h0, rb !== {req, 2'h0}});
        i_pscr_sync_src.level(1'b0, 2);
    endtask
    task automatic t_phase();
        int c0, c10, c63;
        phaseRun(6'h00, c0);
        phaseRun(6'h0a, c10);
        phaseRun(6'h3f, c63);
        chkCnt(c10 - c0, 10);
        chkCnt(c63 - c0, 63);
    endtask
    task automatic gate(input logic [7:0] ctl, input logic f, input logic v, input logic e);
        wr(8'h10, 8'h48);
        wr(8'h10, ctl);
        i_pscr_sync_src.fifo(f);
        i_pscr_sync_src.level(v, 6);
        #1 chk({7'h0, syncLocked}, {7'h0, e});
    endtask
    task automatic t_average(input logic [2:0] code);
        wr(8'h10, 8'h48);
        wr(8'h10, {5'h19, code});
        for (int i = 1; i < (1 << code); i++)
        begin
            i_pscr_sync_src.level(1'b1, 6);
            i_pscr_sync_src.level(1'b0, 6);
        end
        #1 chk({7'h0, syncLocked}, 8'h00);
        i_pscr_sync_src.level(1'b1, 6);
        #1 chk({7'h0, syncLocked}, 8'h01);
        i_pscr_sync_src.level(1'b0, 1);
    endtask
    task automatic wrap_up();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #200us;
        miscompares++;
        wrap_up();
    end
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_registers();
        t_phase();
        gate(8'h48, 1'b1, 1'b1, 1'b0);
        gate(8'hc8, 1'b0, 1'b0, 1'b0);
        gate(8'hc0, 1'b0, 1'b1, 1'b0);
        gate(8'hc0, 1'b0, 1'b0, 1'b1);
        gate(8'h88, 1'b0, 1'b1, 1'b0);
        gate(8'h80, 1'b1, 1'b0, 1'b1);
        i_pscr_sync_src.fifo(1'b0);
        for (int k = 0; k < 8; k++)
            t_average(3'(k));
        wrap_up();
    end
endmodule // test_pscr_regs
